// ### hdl/aclr_consts.svh
`ifndef ACLR_CONSTS_SVH
`define ACLR_CONSTS_SVH

// ----------------------------------------
// remapped vector window
// ----------------------------------------
`define ACLR_VEC_LAST    32'h0000_001C
`define ACLR_WIN_LAST    32'h0000_003F
`define ACLR_WIN_W       6

// ----------------------------------------
// on-chip memories
// ----------------------------------------
`define ACLR_FLASH_BASE  32'h0000_0000
`define ACLR_FLASH_END_S 32'h0001_0000
`define ACLR_FLASH_END_L 32'h0008_0000
`define ACLR_SRAM_BASE   32'h4000_0000
`define ACLR_SRAM_END_S  32'h4000_4000
`define ACLR_SRAM_END_L  32'h4000_8000
`define ACLR_BOOT_BASE   32'h7FFF_E000
`define ACLR_EXT_BASE    32'h8000_0000

// ----------------------------------------
// peripheral areas and slots
// ----------------------------------------
`define ACLR_PB_BASE     32'hE000_0000
`define ACLR_HB_BASE     32'hFFE0_0000
`define ACLR_AREA_LSB    21
`define ACLR_SLOT_LSB    14
`define ACLR_SLOT_W      7
`define ACLR_NSLOT       128
`define ACLR_PB_USED     128'h8000_0000_0000_0000_0000_0000_0D00_2FBF
`define ACLR_PB_AD1      128'h0000_0000_0000_0000_0000_0000_0100_0000
`define ACLR_HB_USED     128'h8000_0000_0000_0000_0000_0000_0000_0000

`endif

// ### hdl/aclr_pkg.sv
package aclr_pkg;

  // mapping modes; 2'h3 is not a legal mode
  typedef enum logic [1:0] {
    MAP_BOOT  = 2'h0,
    MAP_FLASH = 2'h1,
    MAP_RAM   = 2'h2
  } aclr_map_t;

  // memory or bus that serves an access
  typedef enum logic [2:0] {
    TGT_NONE  = 3'h0,
    TGT_FLASH = 3'h1,
    TGT_SRAM  = 3'h2,
    TGT_BOOT  = 3'h3,
    TGT_HB    = 3'h4,
    TGT_PB    = 3'h5
  } aclr_tgt_t;

  // whole registered state of the decoder
  typedef struct packed {
    logic         valid;
    logic         dabort;
    logic         pabort;
    aclr_tgt_t    tgt;
    logic [31:0]  addr;
    logic         wr;
    logic [1:0]   size;
    logic [127:0] hb_sel;
    logic [127:0] pb_sel;
    aclr_map_t    map;
  } aclr_state_t;

endpackage : aclr_pkg

// ### hdl/aclr_slot_dec.sv
`timescale 1ns/10ps
`include "aclr_consts.svh"

module aclr_slot_dec (
  input  wire logic [6:0]   slot,  // slot index from address
  input  wire logic [127:0] used,  // slots that hold a peripheral
  output logic      [127:0] sel,   // one-hot select of assigned slot
  output logic              hit    // slot is assigned
);

  // ----------------------------------------
  // one compare per slot
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < `ACLR_NSLOT; i++) begin : g_slot
      assign sel[i] = used[i] && (slot == 7'(i));
    end
  endgenerate

  // any assigned slot matched
  assign hit = |sel;

endmodule : aclr_slot_dec

// ### hdl/aclr_decoder.sv
`timescale 1ns/10ps
`include "aclr_consts.svh"

// How it works
// - both peripheral areas are 2 MB, split into 128 slots of 16 KB.
// - peripheral select comes from the slot index; slot 127 is system control.
// - peripheral registers are word aligned; no byte-lane steering is done.
// - eight exception vectors sit in words 0x00 to 0x1C.
// - remapped window spans 64 bytes, addresses 0x00 to 0x3F.
// - any reset selects boot loader mapping; boot vectors appear at zero.
// - user flash mapping leaves the window on flash.
// - user RAM mapping serves the window from the bottom of SRAM.
// - boot block sits at the top of on-chip space; all else fixed.
// - remapped memories stay reachable at their own addresses too.
// - the gap between flash end and SRAM aborts.
// - the gap between SRAM end and the boot block aborts.
// - the external memory area always aborts.
// - reserved bus space and unassigned peripheral slots abort.
// - aborts are data aborts for data, prefetch aborts for fetches.
// - fetches from any peripheral space give a prefetch abort.
// - undefined offsets inside an assigned slot do not abort.

module aclr_decoder
  import aclr_pkg::*;
#(
  parameter bit LARGE = 1'b1            // 512 KB flash, 32 KB SRAM part
) (
  input  wire logic          ref_clk,     // system clock
  input  wire logic          resetn,      // chip reset, active low
  input  wire logic          req_valid,   // core access request
  input  wire logic [31:0]   req_addr,    // access address
  input  wire logic          req_write,   // data write
  input  wire logic          req_fetch,   // instruction fetch
  input  wire logic [1:0]    req_size,    // byte, half, word
  input  wire logic          map_wr,      // mapping mode write strobe
  input  wire logic [1:0]    map_val,     // mapping mode written
  output logic               rsp_valid,   // answer to request
  output logic               rsp_dabort,  // data abort
  output logic               rsp_pabort,  // prefetch abort
  output aclr_tgt_t          rsp_tgt,     // serving target
  output logic [31:0]        rsp_addr,    // address at target
  output logic               rsp_write,   // write passed on
  output logic [1:0]         rsp_size,    // size passed on
  output logic [127:0]       hb_sel,      // high-speed bus slot select
  output logic [127:0]       pb_sel,      // peripheral_bus slot select
  output aclr_map_t          map_mode     // active mapping mode
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_metan;
  logic rst_syncn;

  // two flops release the asynchronous reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_metan <= 1'b0;
      rst_syncn <= 1'b0;
    end else begin
      rst_metan <= 1'b1;
      rst_syncn <= rst_metan;
    end
  end

  // ----------------------------------------
  // area bases
  // ----------------------------------------
  // named copies so that the area and window bits can be sliced
  localparam logic [31:0] PB_BASE   = `ACLR_PB_BASE;
  localparam logic [31:0] HB_BASE   = `ACLR_HB_BASE;
  localparam logic [31:0] SRAM_BASE = `ACLR_SRAM_BASE;

  // ----------------------------------------
  // part size
  // ----------------------------------------
  logic [31:0]  flash_end;
  logic [31:0]  sram_end;
  logic [127:0] pb_used;
  logic [127:0] hb_used;

  // memory ends and populated slots of this part
  assign flash_end = LARGE ? `ACLR_FLASH_END_L : `ACLR_FLASH_END_S;
  assign sram_end  = LARGE ? `ACLR_SRAM_END_L : `ACLR_SRAM_END_S;
  assign pb_used   = LARGE ? `ACLR_PB_USED : (`ACLR_PB_USED & ~`ACLR_PB_AD1);
  assign hb_used   = `ACLR_HB_USED;

  // ----------------------------------------
  // region decode
  // ----------------------------------------
  logic [6:0]   slot;
  logic         in_win;
  logic         in_flash;
  logic         in_sram;
  logic         in_boot;
  logic         in_pb;
  logic         in_hb;
  logic         pb_hit;
  logic         hb_hit;
  logic [127:0] pb_dec;
  logic [127:0] hb_dec;
  logic         mem_ok;
  logic         per_ok;

  // slot index is address bits 20:14 in both areas
  assign slot     = req_addr[`ACLR_SLOT_LSB +: `ACLR_SLOT_W];

  // window holds the vectors 0x00..0x1C and 32 more bytes
  assign in_win   = req_addr <= `ACLR_WIN_LAST;
  assign in_flash = req_addr < flash_end;
  assign in_sram  = (req_addr >= `ACLR_SRAM_BASE) && (req_addr < sram_end);

  // boot block tops the on-chip space; gaps below it abort
  assign in_boot  = (req_addr >= `ACLR_BOOT_BASE) && (req_addr < `ACLR_EXT_BASE);
  assign in_pb    = req_addr[31:`ACLR_AREA_LSB] == PB_BASE[31:`ACLR_AREA_LSB];
  assign in_hb    = req_addr[31:`ACLR_AREA_LSB] == HB_BASE[31:`ACLR_AREA_LSB];

  // one slot decoder per peripheral area
  aclr_slot_dec u_pb_dec (
    .slot (slot),
    .used (pb_used),
    .sel  (pb_dec),
    .hit  (pb_hit)
  );

  aclr_slot_dec u_hb_dec (
    .slot (slot),
    .used (hb_used),
    .sel  (hb_dec),
    .hit  (hb_hit)
  );

  // flash, SRAM and boot block answer at their own addresses
  assign mem_ok = in_flash || in_sram || in_boot;

  // only assigned slots exist; reserved space falls through
  assign per_ok = (in_pb && pb_hit) || (in_hb && hb_hit);

  // ----------------------------------------
  // state update
  // ----------------------------------------
  aclr_state_t q;
  aclr_state_t next_q;

  // decode one request per cycle into the next answer
  always_comb begin
    next_q        = q;
    next_q.valid  = req_valid;
    next_q.dabort = 1'b0;
    next_q.pabort = 1'b0;
    next_q.tgt    = TGT_NONE;
    next_q.addr   = 32'h0000_0000;
    next_q.wr     = 1'b0;
    next_q.size   = 2'h0;
    next_q.hb_sel = '0;
    next_q.pb_sel = '0;
    // illegal code leaves the mode as it was
    if (map_wr && (map_val != 2'h3)) begin
      next_q.map = aclr_map_t'(map_val);
    end
    if (req_valid) begin
      next_q.size = req_size;
      next_q.wr   = req_write;
      if (in_win) begin
        unique case (q.map)
          MAP_BOOT: begin
            next_q.tgt  = TGT_BOOT;
            next_q.addr = `ACLR_BOOT_BASE | {26'h0, req_addr[5:0]};
          end
          MAP_RAM: begin
            next_q.tgt  = TGT_SRAM;
            next_q.addr = `ACLR_SRAM_BASE | {26'h0, req_addr[5:0]};
          end
          default: begin
            next_q.tgt  = TGT_FLASH;
            next_q.addr = req_addr;
          end
        endcase
      end else if (mem_ok) begin
        next_q.addr = req_addr;
        if (in_flash) begin
          next_q.tgt = TGT_FLASH;
        end else if (in_sram) begin
          next_q.tgt = TGT_SRAM;
        end else begin
          next_q.tgt = TGT_BOOT;
        end
      end else if (per_ok && !req_fetch) begin
        // registers are whole words; low address bits dropped
        next_q.addr   = {req_addr[31:2], 2'h0};
        // any offset inside an assigned slot reaches it
        next_q.tgt    = in_pb ? TGT_PB : TGT_HB;
        next_q.pb_sel = in_pb ? pb_dec : '0;
        next_q.hb_sel = in_hb ? hb_dec : '0;
      end else begin
        // refused: nothing selected, nothing written
        next_q.wr     = 1'b0;
        // fetch from peripheral space lands here too
        next_q.pabort = req_fetch;
        next_q.dabort = !req_fetch;
      end
    end
  end

  // whole state on one register; reset gives boot mapping
  always_ff @(posedge ref_clk or negedge rst_syncn) begin
    if (!rst_syncn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // prefetch abort travels with the fetch answer for the core
  assign rsp_valid  = q.valid;
  assign rsp_dabort = q.dabort;
  assign rsp_pabort = q.pabort;
  assign rsp_tgt    = q.tgt;
  assign rsp_addr   = q.addr;
  assign rsp_write  = q.wr;
  assign rsp_size   = q.size;
  assign hb_sel     = q.hb_sel;
  assign pb_sel     = q.pb_sel;
  assign map_mode   = q.map;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_syncn);

  // every request answered on the next edge
  resp_timing_a: assert property (req_valid |=> rsp_valid ##1 (rsp_valid == $past(req_valid)))
    else $error("answer not one cycle after request");

  // one abort kind at a time
  abort_kind_a: assert property (rsp_valid |-> !(rsp_dabort && rsp_pabort))
    else $error("both abort kinds raised");

  // fetches from peripheral space always abort
  fetch_periph_a: assert property (req_valid && req_fetch && (in_pb || in_hb) |=> rsp_pabort)
    else $error("peripheral fetch not aborted");

  // flash to SRAM gap gives data abort
  flash_gap_a: assert property (req_valid && !req_fetch && (req_addr >= flash_end)
                                && (req_addr < `ACLR_SRAM_BASE) |=> rsp_dabort)
    else $error("flash gap access not aborted");

  // SRAM to boot gap aborts
  sram_gap_a: assert property (req_valid && req_fetch && (req_addr >= sram_end)
                               && (req_addr < `ACLR_BOOT_BASE) |=> rsp_pabort)
    else $error("sram gap fetch not aborted");

  // external area aborts
  ext_area_a: assert property (req_valid && !req_fetch && (req_addr >= `ACLR_EXT_BASE)
                               && (req_addr < `ACLR_PB_BASE) |=> rsp_dabort)
    else $error("external access not aborted");

  // boot mapping serves window from boot block
  win_boot_a: assert property (req_valid && in_win && (map_mode == MAP_BOOT) |=>
                               (rsp_tgt == TGT_BOOT) && (rsp_addr[5:0] == $past(req_addr[5:0])))
    else $error("window not on boot block");

  // RAM mapping serves window from SRAM base
  win_ram_a: assert property (req_valid && in_win && (map_mode == MAP_RAM) |=>
                              (rsp_tgt == TGT_SRAM) && (rsp_addr[31:6] == SRAM_BASE[31:6]))
    else $error("window not on sram");

  // flash mapping leaves window untouched
  win_flash_a: assert property (req_valid && in_win && (map_mode == MAP_FLASH) |=>
                                (rsp_tgt == TGT_FLASH) && (rsp_addr == $past(req_addr)))
    else $error("window moved in flash mode");

  // boot block answers at its own address
  boot_home_a: assert property (req_valid && in_boot |=> (rsp_tgt == TGT_BOOT))
    else $error("boot block lost at home address");

  // aborted access selects and writes nothing
  abort_quiet_a: assert property ((rsp_dabort || rsp_pabort) |->
                                  (rsp_tgt == TGT_NONE) && !rsp_write && (pb_sel == '0) && (hb_sel == '0))
    else $error("aborted access has side effects");

  // assigned slot gets exactly its own select
  slot_select_a: assert property (req_valid && !req_fetch && in_pb && pb_used[slot] |=>
                                  (pb_sel == (128'h1 << $past(slot))) && !rsp_dabort)
    else $error("peripheral slot select wrong");

  // unassigned slot aborts
  slot_free_a: assert property (req_valid && !req_fetch && in_pb && !pb_used[slot] |=> rsp_dabort)
    else $error("unassigned slot not aborted");

  // peripheral address is word aligned
  word_align_a: assert property (rsp_valid && ((rsp_tgt == TGT_PB) || (rsp_tgt == TGT_HB)) |->
                                 (rsp_addr[1:0] == 2'h0))
    else $error("peripheral address not aligned");

  // mode holds unless written legally
  map_hold_a: assert property (!map_wr || (map_val == 2'h3) |=> $stable(map_mode))
    else $error("mapping mode changed without write");

  // window accesses never abort, whatever the mode
  win_safe_a: assert property (req_valid && in_win |=> !rsp_dabort && !rsp_pabort)
    else $error("window access aborted");

  // vectors come from the boot block after reset
  vec_boot_a: assert property (req_valid && (req_addr <= `ACLR_VEC_LAST) && (map_mode == MAP_BOOT) |=>
                               (rsp_addr == (`ACLR_BOOT_BASE | $past(req_addr))))
    else $error("vector not taken from boot block");

  // flash outside the window stays in place
  flash_home_a: assert property (req_valid && !in_win && in_flash |=>
                                 (rsp_tgt == TGT_FLASH) && (rsp_addr == $past(req_addr)))
    else $error("flash access moved");

  // SRAM answers at its own address in every mode
  sram_home_a: assert property (req_valid && in_sram |=>
                                (rsp_tgt == TGT_SRAM) && (rsp_addr == $past(req_addr)))
    else $error("sram access moved");

  // reserved space above the peripheral_bus area aborts
  resv_area_a: assert property (req_valid && !req_fetch && !in_pb && !in_hb && (req_addr >= `ACLR_PB_BASE) |=>
                                rsp_dabort)
    else $error("reserved space not aborted");

  // unassigned high-speed bus slot aborts
  hb_free_a: assert property (req_valid && !req_fetch && in_hb && !hb_used[slot] |=> rsp_dabort)
    else $error("unassigned high-speed slot not aborted");

  // assigned high-speed bus slot gets its own select
  hb_select_a: assert property (req_valid && !req_fetch && in_hb && hb_used[slot] |=>
                                (hb_sel == (128'h1 << $past(slot))) && (rsp_tgt == TGT_HB))
    else $error("high-speed slot select wrong");

  // no request, no answer and nothing passed on
  idle_quiet_a: assert property (!req_valid |=> !rsp_valid && (rsp_tgt == TGT_NONE) && !rsp_write)
    else $error("answer without request");

endmodule : aclr_decoder

// ### tb/aclr_core_model.sv
`timescale 1ns/10ps

// ----------------------------------------
// core side: abort flag held with a fetch
// ----------------------------------------
module aclr_core_model (
  input  wire logic ref_clk,     // system clock
  input  wire logic resetn,      // reset, active low
  input  wire logic fetch_done,  // answer to a fetch
  input  wire logic fetch_abort, // prefetch abort seen
  input  wire logic flush,       // pipeline flushed
  input  wire logic exec,        // held word executes
  output logic      abort_taken  // exception taken
);
  logic held; // abort flag kept beside the word

  // flag travels with the fetched word; a flush drops it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) held <= 1'b0;
    else if (flush) held <= 1'b0;
    else if (fetch_done) held <= fetch_abort;
  end

  // exception only when the word reaches execution
  assign abort_taken = exec & held;
endmodule : aclr_core_model

// ### tb/address_decode_remap_abort_test.sv
`timescale 1ns/10ps
`include "aclr_consts.svh"

module address_decode_remap_abort_test;
  import aclr_pkg::*;
  logic         ref_clk, resetn, req_valid, req_write, req_fetch, map_wr;
  logic         flush, exec, abort_taken, rsp_valid, rsp_dabort, rsp_pabort, rsp_write;
  logic [31:0]  req_addr, rsp_addr, lfsr;
  logic [1:0]   req_size, map_val, rsp_size;
  logic [127:0] hb_sel, pb_sel;
  aclr_tgt_t    rsp_tgt;
  aclr_map_t    map_mode, cur;
  int           num_errors, total_checks;
  localparam logic [127:0] PB_USED = `ACLR_PB_USED;
  logic [31:0]  corner [24] = '{32'h0, 32'h1C, 32'h3F, 32'h40, 32'h7FFFC, 32'h80000,
    32'h3FFFFFFF, 32'h40000000, 32'h40007FFF, 32'h40008000, 32'h7FFFDFFF, 32'h7FFFE000,
    32'h7FFFFFFF, 32'h80000000, 32'hDFFFFFFF, 32'hE0000000, 32'hE000D000, 32'hE0018000,
    32'hE0060000, 32'hE01FC040, 32'hE0200000, 32'hFFDFFFFF, 32'hFFE00000, 32'hFFFFC002};
  logic [31:0]  bases [8] = '{32'h0, 32'h0, 32'h40000000, 32'h7FFFE000, 32'hE0000000,
    32'hE01F0000, 32'hFFE00000, 32'h80000000};

  aclr_decoder u_aclr_decoder (.ref_clk(ref_clk), .resetn(resetn), .req_valid(req_valid),
    .req_addr(req_addr), .req_write(req_write), .req_fetch(req_fetch), .req_size(req_size),
    .map_wr(map_wr), .map_val(map_val), .rsp_valid(rsp_valid), .rsp_dabort(rsp_dabort),
    .rsp_pabort(rsp_pabort), .rsp_tgt(rsp_tgt), .rsp_addr(rsp_addr), .rsp_write(rsp_write),
    .rsp_size(rsp_size), .hb_sel(hb_sel), .pb_sel(pb_sel), .map_mode(map_mode));

  aclr_core_model u_aclr_core_model (.ref_clk(ref_clk), .resetn(resetn), .fetch_done(rsp_valid),
    .fetch_abort(rsp_pabort), .flush(flush), .exec(exec), .abort_taken(abort_taken));

  // ----------------------------------------
  // expectations and helpers
  // ----------------------------------------
  // {dabort, pabort, target, address} for one access
  function automatic logic [36:0] exp_rsp(input logic [31:0] a, input logic f);
    logic ab;
    aclr_tgt_t t;
    logic [31:0] o;
    ab = 1'b0;
    o = a;
    t = TGT_NONE;
    if (a <= `ACLR_WIN_LAST) begin
      t = (cur == MAP_BOOT) ? TGT_BOOT : (cur == MAP_RAM) ? TGT_SRAM : TGT_FLASH;
      o = (cur == MAP_BOOT) ? (`ACLR_BOOT_BASE | a) : (cur == MAP_RAM) ? (`ACLR_SRAM_BASE | a) : a;
    end else if (a < `ACLR_FLASH_END_L) t = TGT_FLASH;
    else if (a >= `ACLR_SRAM_BASE && a < `ACLR_SRAM_END_L) t = TGT_SRAM;
    else if (a >= `ACLR_BOOT_BASE && a < `ACLR_EXT_BASE) t = TGT_BOOT;
    else if (a >= `ACLR_PB_BASE && a < 32'hE020_0000) begin
      ab = f | ~PB_USED[a[20:14]];
      t = TGT_PB;
      o = {a[31:2], 2'h0};
    end else if (a >= `ACLR_HB_BASE) begin
      ab = f | (a[20:14] != 7'h7F);
      t = TGT_HB;
      o = {a[31:2], 2'h0};
    end else ab = 1'b1;
    if (ab) begin
      t = TGT_NONE;
      o = 32'h0;
    end
    return {ab & ~f, ab & f, t, o};
  endfunction : exp_rsp

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C1_1DB7 : 32'h0);
  endfunction : nxt

  task automatic chk(input logic [127:0] seen, input logic [127:0] want);
    total_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : chk

  // one request, answered at the next edge
  task automatic req(input logic [31:0] a, input logic f, input logic w, input logic [1:0] s);
    logic [36:0] e;
    e = exp_rsp(a, f);
    req_valid = 1'b1;
    req_addr = a;
    req_fetch = f;
    req_write = w;
    req_size = s;
    @(posedge ref_clk);
    #1;
    chk(rsp_valid, 128'h1);
    chk({rsp_dabort, rsp_pabort}, e[36:35]);
    chk(rsp_tgt, e[34:32]);
    chk(rsp_addr, e[31:0]);
    chk({rsp_write, rsp_size}, {w & ~|e[36:35], s});
    chk(pb_sel, (e[34:32] == TGT_PB) ? 128'h1 << a[20:14] : 128'h0);
    chk(hb_sel, (e[34:32] == TGT_HB) ? 128'h1 << a[20:14] : 128'h0);
  endtask : req

  task automatic idle();
    req_valid = 1'b0;
    @(posedge ref_clk);
    #1;
    chk(rsp_valid, 128'h0);
  endtask : idle

  task automatic setmap(input logic [1:0] v);
    map_wr = 1'b1;
    map_val = v;
    @(posedge ref_clk);
    #1;
    map_wr = 1'b0;
    if (v != 2'h3) cur = aclr_map_t'(v);
    @(posedge ref_clk);
    #1;
    chk(map_mode, cur);
  endtask : setmap

  task automatic do_reset(input int n);
    resetn = 1'b0;
    repeat (n) @(posedge ref_clk);
    #1;
    chk({rsp_valid, map_mode, rsp_tgt}, 128'h0);
    resetn = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    cur = MAP_BOOT;
    chk(map_mode, MAP_BOOT);
  endtask : do_reset

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  // ----------------------------------------
  // clock, watchdog and test sequence
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    #60000;
    num_errors++;
    summarize();
  end

  initial begin
    {req_valid, req_write, req_fetch, map_wr, flush, exec} = 6'h0;
    {req_addr, req_size, map_val} = 36'h0;
    num_errors = 0;
    total_checks = 0;
    cur = MAP_BOOT;
    lfsr = 32'h47EC;
    do_reset(10);
    // every corner, fetch and data, in each mapping mode
    for (int m = 0; m < 3; m++) begin
      if (m > 0) setmap(m[1:0]);
      foreach (corner[i]) for (int f = 0; f < 2; f++) req(corner[i], f[0], ~f[0], 2'h2);
      idle();
    end
    setmap(2'h3);
    $display("test corners done");
    // write and request in one cycle: old mode serves it
    map_wr = 1'b1;
    map_val = 2'h1;
    req(32'h20, 1'b0, 1'b1, 2'h1);
    map_wr = 1'b0;
    cur = MAP_FLASH;
    idle();
    chk(map_mode, MAP_FLASH);
    $display("test same cycle done");
    repeat (300) begin
      lfsr = nxt(lfsr);
      if (lfsr[12:10] == 3'h0) begin
        idle();
        setmap(lfsr[9:8]);
      end
      req(bases[lfsr[2:0]] + {13'h0, lfsr[31:13]}, lfsr[3], lfsr[4] & ~lfsr[3],
          (lfsr[6:5] == 2'h3) ? 2'h2 : lfsr[6:5]);
    end
    idle();
    $display("test random done");
    // flushed aborted fetch is never taken, executed one is
    req(32'hE000_0000, 1'b1, 1'b0, 2'h2);
    idle();
    flush = 1'b1;
    @(posedge ref_clk);
    #1;
    flush = 1'b0;
    exec = 1'b1;
    #1;
    chk(abort_taken, 128'h0);
    @(posedge ref_clk);
    #1;
    exec = 1'b0;
    req(32'hE01F_C000, 1'b1, 1'b0, 2'h2);
    idle();
    exec = 1'b1;
    #1;
    chk(abort_taken, 128'h1);
    @(posedge ref_clk);
    #1;
    exec = 1'b0;
    $display("test core done");
    // mid-run reset returns to boot loader mapping
    setmap(2'h2);
    do_reset(2);
    req(32'h0, 1'b1, 1'b0, 2'h2);
    idle();
    $display("test reset done");
    summarize();
  end
endmodule : address_decode_remap_abort_test
